// ==== hdl/dmbo_pkg.sv ====
// Constants and carrier types for the display memory bank offset block
package dmbo_pkg;
   // I/O ports of the index/data register pair
   localparam logic [15:0] DMBO_INDEX_PORT = 16'h03CE;
   localparam logic [15:0] DMBO_DATA_PORT  = 16'h03CF;
   // Register indices
   localparam logic [7:0]  DMBO_IDX_OFS0   = 8'h09;
   localparam logic [7:0]  DMBO_IDX_OFS1   = 8'h0A;
   localparam logic [7:0]  DMBO_IDX_MODE   = 8'h0B;
   // Reset values
   localparam logic [7:0]  DMBO_OFS0_RST   = 8'h0F;
   localparam logic [7:0]  DMBO_OFS1_RST   = 8'h0F;
   localparam logic [7:0]  DMBO_MODE_RST   = 8'h0F;
   localparam logic [7:0]  DMBO_INDEX_RST  = 8'h00;
   // Mode extension fields; bits 7:6 are reserved and read as zero
   localparam int          DMBO_OFS1_EN    = 0;
   localparam int          DMBO_BY8_EN     = 1;
   localparam int          DMBO_EXTWR_EN   = 2;
   localparam int          DMBO_LATCH8_EN  = 3;
   localparam int          DMBO_PIX16_EN   = 4;
   localparam int          DMBO_GRAN_16K   = 5;
   localparam logic [7:0]  DMBO_MODE_MASK  = 8'h3F;
   // Memory map select codes
   localparam logic [1:0]  DMBO_MAP_128K   = 2'h0;
   localparam logic [1:0]  DMBO_MAP_64K    = 2'h1;
   // Address shifts and bytes written per CPU byte
   localparam logic [2:0]  DMBO_SHIFT_NONE = 3'h0;
   localparam logic [2:0]  DMBO_SHIFT_BY8  = 3'h3;
   localparam logic [2:0]  DMBO_SHIFT_BY16 = 3'h4;
   localparam logic [4:0]  DMBO_XFER_1     = 5'h01;
   localparam logic [4:0]  DMBO_XFER_8     = 5'h08;
   localparam logic [4:0]  DMBO_XFER_16    = 5'h10;

   // Alignment of the offset against the forced bus address
   typedef enum logic [1:0] {
      DMBO_ALIGN_4K  = 2'b00,
      DMBO_ALIGN_16K = 2'b01,
      DMBO_ALIGN_LIN = 2'b10
   } dmbo_align_t;

   // CPU address: a = A[20:12], la = linear high address bits 20..17
   typedef struct packed {
      logic [8:0] a;
      logic [3:0] la;
   } dmbo_cpu_addr_t;

   // Write path configuration handed to the memory write datapath
   typedef struct packed {
      logic [2:0] shift;
      logic [4:0] xfer_bytes;
      logic       latch8;
      logic       color_ext;
      logic       mask_dbl;
   } dmbo_wr_mode_t;
endpackage : dmbo_pkg

// ==== hdl/dmbo_offset_adder.sv ====
// Offset adder forming the pre-wrap display memory address bits 20..12
module dmbo_offset_adder (
   // Clock and reset
   input  wire logic                CLK_SYS_I,
   input  wire logic                RST_I,
   // Operands
   input  wire dmbo_pkg::dmbo_align_t align_i,
   input  wire logic [8:0]          xa_i,
   input  wire logic [3:0]          la_i,
   input  wire logic [7:0]          offset_i,
   // Result, bit 0 is address bit 12
   output logic [8:0]               xma_o
);
   logic [7:0] sum_4k;
   logic [6:0] sum_16k;
   logic [6:0] sum_lin;
   logic [8:0] xma_d;

   // Carries beyond the top bit fall off by width
   always_comb
   begin
      sum_4k  = {3'h0, xa_i[4:0]} + offset_i;
      sum_16k = {4'h0, xa_i[4:2]} + offset_i[6:0];
      sum_lin = {la_i, xa_i[4:2]} + offset_i[6:0];
      unique case (align_i)
         dmbo_pkg::DMBO_ALIGN_4K:  xma_d = {1'b0, sum_4k};
         dmbo_pkg::DMBO_ALIGN_16K: xma_d = {sum_16k, xa_i[1:0]};
         dmbo_pkg::DMBO_ALIGN_LIN: xma_d = {sum_lin, xa_i[1:0]};
         default:                  xma_d = 9'h000;
      endcase
   end

   // Registered so the address path meets timing in one cycle
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         xma_o <= 9'h000;
      else
         xma_o <= xma_d;
   end
endmodule : dmbo_offset_adder

// ==== hdl/dmbo_top.sv ====
// Display memory bank offset: registers, address forcing and write mode control
module dmbo_top (
   // Clock and reset
   input  wire logic                    CLK_SYS_I,
   input  wire logic                    RST_I,
   // Host I/O register port
   input  wire logic [15:0]             IO_ADDR_I,
   input  wire logic                    IO_WR_I,
   input  wire logic                    IO_RD_I,
   input  wire logic [7:0]              IO_WDATA_I,
   output logic [7:0]                   IO_RDATA_O,
   output logic                         IO_RD_HIT_O,
   // CPU address and system configuration
   input  wire dmbo_pkg::dmbo_cpu_addr_t CPU_ADDR_I,
   input  wire logic                    LINEAR_MODE_I,
   input  wire logic [3:0]              LINEAR_PAGE_REG_I,
   input  wire logic [1:0]              MEMORY_MAP_SELECT_REG_I,
   input  wire logic                    PCI_MODE_I,
   input  wire logic                    DUAL_BE_APERTURE_I,
   input  wire logic                    EXT_WR_MODE45_I,
   // Colour and mask sources
   input  wire logic [7:0]              FG_COLOR_I,
   input  wire logic [7:0]              BG_COLOR_I,
   input  wire logic [7:0]              FOREGROUND_COLOR_EXT_I,
   input  wire logic [7:0]              BACKGROUND_COLOR_EXT_I,
   input  wire logic [7:0]              PLANE_WRITE_MASK_I,
   // Address results
   output logic [8:0]                   PREWRAP_MEMORY_ADDRESS_O,
   output logic                         OFFSET_SELECT_O,
   output logic                         OFFSETS_BLOCKED_O,
   output logic [3:0]                   LINEAR_PAGE_O,
   // Write datapath control
   output dmbo_pkg::dmbo_wr_mode_t      WR_MODE_O,
   output logic [15:0]                  FG_COLOR_O,
   output logic [15:0]                  BG_COLOR_O,
   output logic [15:0]                  BYTE_WRITE_MASK_O
);
   logic [7:0]            index_q;
   logic [7:0]            bank_offset_zero_q;
   logic [7:0]            bank_offset_one_q;
   logic [7:0]            write_mode_extensions_q;
   logic                  idx_wr;
   logic                  data_wr;
   logic                  ofs1_en;
   logic                  gran_16k;
   logic                  pix16_eff;
   logic                  enh_active;
   logic                  sel_one;
   logic                  blocked;
   logic [8:0]            forced_bus_address;
   logic [7:0]            chosen_offset;
   logic [15:0]           byte_mask_d;
   dmbo_pkg::dmbo_align_t align;

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);

   // Port decode; host logic shares this clock so no synchronisers
   assign idx_wr  = IO_WR_I && (IO_ADDR_I == dmbo_pkg::DMBO_INDEX_PORT);
   assign data_wr = IO_WR_I && (IO_ADDR_I == dmbo_pkg::DMBO_DATA_PORT);

   // Index register
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         index_q <= dmbo_pkg::DMBO_INDEX_RST;
      else if (idx_wr)
         index_q <= IO_WDATA_I;
   end

   // Offset registers
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         bank_offset_zero_q <= dmbo_pkg::DMBO_OFS0_RST;
         bank_offset_one_q  <= dmbo_pkg::DMBO_OFS1_RST;
      end
      else if (data_wr)
      begin
         if (index_q == dmbo_pkg::DMBO_IDX_OFS0)
            bank_offset_zero_q <= IO_WDATA_I;
         if (index_q == dmbo_pkg::DMBO_IDX_OFS1)
            bank_offset_one_q <= IO_WDATA_I;
      end
   end

   // Mode extension register; reserved bits are never stored
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         write_mode_extensions_q <= dmbo_pkg::DMBO_MODE_RST;
      else if (data_wr && (index_q == dmbo_pkg::DMBO_IDX_MODE))
         write_mode_extensions_q <= IO_WDATA_I & dmbo_pkg::DMBO_MODE_MASK;
   end

   // Read port: index and mapped registers answer, other indices read zero
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         IO_RDATA_O  <= 8'h00;
         IO_RD_HIT_O <= 1'b0;
      end
      else
      begin
         IO_RD_HIT_O <= 1'b0;
         if (IO_RD_I && (IO_ADDR_I == dmbo_pkg::DMBO_INDEX_PORT))
         begin
            IO_RDATA_O  <= index_q;
            IO_RD_HIT_O <= 1'b1;
         end
         else if (IO_RD_I && (IO_ADDR_I == dmbo_pkg::DMBO_DATA_PORT))
         begin
            IO_RD_HIT_O <= 1'b1;
            unique case (index_q)
               dmbo_pkg::DMBO_IDX_OFS0: IO_RDATA_O <= bank_offset_zero_q;
               dmbo_pkg::DMBO_IDX_OFS1: IO_RDATA_O <= bank_offset_one_q;
               dmbo_pkg::DMBO_IDX_MODE: IO_RDATA_O <= write_mode_extensions_q;
               default:
               begin
                  IO_RDATA_O  <= 8'h00;
                  IO_RD_HIT_O <= 1'b0;
               end
            endcase
         end
      end
   end

   // Mode decode
   assign ofs1_en    = write_mode_extensions_q[dmbo_pkg::DMBO_OFS1_EN];
   assign gran_16k   = write_mode_extensions_q[dmbo_pkg::DMBO_GRAN_16K];
   // Pixel enhancement is dead unless extended writes are on
   assign pix16_eff  = write_mode_extensions_q[dmbo_pkg::DMBO_PIX16_EN] &&
                       write_mode_extensions_q[dmbo_pkg::DMBO_EXTWR_EN];
   assign enh_active = pix16_eff && EXT_WR_MODE45_I;

   // Offset choice: bit 15 only matters with offset-one on
   assign sel_one = ofs1_en && CPU_ADDR_I.a[3];
   // Big-endian dual aperture on PCI bypasses both offsets
   assign blocked = PCI_MODE_I && DUAL_BE_APERTURE_I;
   assign chosen_offset = blocked ? 8'h00 :
                          (sel_one ? bank_offset_one_q : bank_offset_zero_q);

   // Forced bus address; bit 3 is A15, bit 4 is A16
   always_comb
   begin
      forced_bus_address = CPU_ADDR_I.a;
      if ((MEMORY_MAP_SELECT_REG_I == dmbo_pkg::DMBO_MAP_64K) || ofs1_en)
         forced_bus_address[4] = 1'b0;
      if (ofs1_en)
         forced_bus_address[3] = 1'b0;
   end

   // Alignment choice; the linear variant only exists at 16K steps
   always_comb
   begin
      if (!gran_16k)
         align = dmbo_pkg::DMBO_ALIGN_4K;
      else if (LINEAR_MODE_I)
         align = dmbo_pkg::DMBO_ALIGN_LIN;
      else
         align = dmbo_pkg::DMBO_ALIGN_16K;
   end

   // Sum of forced address and offset, registered inside
   dmbo_offset_adder u_adder (
      .CLK_SYS_I (CLK_SYS_I),
      .RST_I     (RST_I),
      .align_i   (align),
      .xa_i      (forced_bus_address),
      .la_i      (CPU_ADDR_I.la),
      .offset_i  (chosen_offset),
      .xma_o     (PREWRAP_MEMORY_ADDRESS_O)
   );

   // Selection flags and linear page, registered alongside the sum
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         OFFSET_SELECT_O   <= 1'b0;
         OFFSETS_BLOCKED_O <= 1'b0;
         LINEAR_PAGE_O     <= 4'h0;
      end
      else
      begin
         OFFSET_SELECT_O   <= sel_one;
         OFFSETS_BLOCKED_O <= blocked;
         // 2M aperture on a 2M boundary: lowest page bit dropped
         LINEAR_PAGE_O     <= {LINEAR_PAGE_REG_I[3:1],
                               LINEAR_PAGE_REG_I[0] & ~gran_16k};
      end
   end

   // Write mode control for the datapath
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         WR_MODE_O <= '0;
      else
      begin
         WR_MODE_O.latch8    <= write_mode_extensions_q[dmbo_pkg::DMBO_LATCH8_EN];
         WR_MODE_O.color_ext <= enh_active;
         WR_MODE_O.mask_dbl  <= enh_active;
         if (enh_active)
         begin
            WR_MODE_O.shift      <= dmbo_pkg::DMBO_SHIFT_BY16;
            WR_MODE_O.xfer_bytes <= dmbo_pkg::DMBO_XFER_16;
         end
         else if (write_mode_extensions_q[dmbo_pkg::DMBO_BY8_EN] && !pix16_eff)
         begin
            // By-8 is a don't-care once the enhancement owns the path
            WR_MODE_O.shift      <= dmbo_pkg::DMBO_SHIFT_BY8;
            WR_MODE_O.xfer_bytes <= dmbo_pkg::DMBO_XFER_8;
         end
         else
         begin
            WR_MODE_O.shift      <= dmbo_pkg::DMBO_SHIFT_NONE;
            WR_MODE_O.xfer_bytes <= dmbo_pkg::DMBO_XFER_1;
         end
      end
   end

   // Byte mask: one plane bit per pixel of two bytes when enhanced
   for (genvar j = 0; j < 16; j++)
   begin : g_mask
      if (j < 8)
      begin : g_lo
         assign byte_mask_d[j] = enh_active ? PLANE_WRITE_MASK_I[j / 2]
                                            : PLANE_WRITE_MASK_I[j];
      end
      else
      begin : g_hi
         assign byte_mask_d[j] = enh_active && PLANE_WRITE_MASK_I[j / 2];
      end
   end

   // Colours: high bytes come from the extensions only when enhanced
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         FG_COLOR_O        <= 16'h0000;
         BG_COLOR_O        <= 16'h0000;
         BYTE_WRITE_MASK_O <= 16'h0000;
      end
      else
      begin
         FG_COLOR_O <= {enh_active ? FOREGROUND_COLOR_EXT_I : 8'h00, FG_COLOR_I};
         BG_COLOR_O <= {enh_active ? BACKGROUND_COLOR_EXT_I : 8'h00, BG_COLOR_I};
         BYTE_WRITE_MASK_O <= byte_mask_d;
      end
   end

   // Checks on the address path
   sel_zero_a : assert property (
      (!ofs1_en || !CPU_ADDR_I.a[3]) |=> !OFFSET_SELECT_O)
      else $error("offset zero not selected");
   sel_one_a : assert property (
      (ofs1_en && CPU_ADDR_I.a[3]) |=> OFFSET_SELECT_O)
      else $error("offset one not selected");
   ofs1_ignored_a : assert property (
      !ofs1_en |-> (blocked || chosen_offset == bank_offset_zero_q))
      else $error("offset one used while disabled");
   block_4k_a : assert property (
      (blocked && !gran_16k) |=>
         OFFSETS_BLOCKED_O && PREWRAP_MEMORY_ADDRESS_O == {4'h0, $past(forced_bus_address[4:0])})
      else $error("blocked offset still added");
   sum_4k_a : assert property (
      (!blocked && !gran_16k) |=> PREWRAP_MEMORY_ADDRESS_O ==
         {1'b0, $past({3'h0, forced_bus_address[4:0]}) + $past(chosen_offset)})
      else $error("4K sum wrong");
   carry_drop_a : assert property (
      !gran_16k |=> !PREWRAP_MEMORY_ADDRESS_O[8])
      else $error("carry reached bit 20 in 4K mode");
   low_pass_a : assert property (
      gran_16k |=> PREWRAP_MEMORY_ADDRESS_O[1:0] == $past(CPU_ADDR_I.a[1:0]))
      else $error("bits 13..12 not passed");
   lin_sum_a : assert property (
      (gran_16k && LINEAR_MODE_I && !blocked) |=> PREWRAP_MEMORY_ADDRESS_O[8:2] ==
         $past({CPU_ADDR_I.la, forced_bus_address[4:2]}) + $past(chosen_offset[6:0]))
      else $error("linear 16K sum wrong");
   map128_a : assert property (
      (MEMORY_MAP_SELECT_REG_I == dmbo_pkg::DMBO_MAP_128K && !ofs1_en) |->
         forced_bus_address == CPU_ADDR_I.a)
      else $error("128K map altered the address");
   force64_a : assert property (
      (MEMORY_MAP_SELECT_REG_I == dmbo_pkg::DMBO_MAP_64K && !ofs1_en) |->
         !forced_bus_address[4] && forced_bus_address[3] == CPU_ADDR_I.a[3])
      else $error("64K map forcing wrong");
   force_both_a : assert property (
      ofs1_en |-> forced_bus_address[4:3] == 2'h0)
      else $error("bits 16..15 not forced");
   page_drop_a : assert property (
      gran_16k |=> !LINEAR_PAGE_O[0])
      else $error("page bit kept at 16K granularity");

   // Checks on the write path
   shift16_a : assert property (
      enh_active |=> WR_MODE_O.shift == dmbo_pkg::DMBO_SHIFT_BY16
         && WR_MODE_O.xfer_bytes == dmbo_pkg::DMBO_XFER_16)
      else $error("enhanced shift or count wrong");
   needs_ext_a : assert property (
      !write_mode_extensions_q[dmbo_pkg::DMBO_EXTWR_EN] |=>
         WR_MODE_O.shift != dmbo_pkg::DMBO_SHIFT_BY16 && !WR_MODE_O.mask_dbl)
      else $error("enhancement active without extended writes");
   shift8_a : assert property (
      (write_mode_extensions_q[dmbo_pkg::DMBO_BY8_EN] && !pix16_eff) |=>
         WR_MODE_O.shift == dmbo_pkg::DMBO_SHIFT_BY8)
      else $error("by-8 shift missing");
   color_ext_a : assert property (
      enh_active |=> FG_COLOR_O[15:8] == $past(FOREGROUND_COLOR_EXT_I)
         && BG_COLOR_O[15:8] == $past(BACKGROUND_COLOR_EXT_I))
      else $error("colour extension not applied");
   mask_pair_a : assert property (
      enh_active |=> BYTE_WRITE_MASK_O[15:14] == {2{$past(PLANE_WRITE_MASK_I[7])}}
         && BYTE_WRITE_MASK_O[1:0] == {2{$past(PLANE_WRITE_MASK_I[0])}})
      else $error("plane mask not doubled");
endmodule : dmbo_top

// ==== verification/dmbo_host_model.sv ====
// Host CPU model driving the index/data register port
module dmbo_host_model (
   // Clock
   input  wire logic        clk_i,
   // Register port
   output logic [15:0]      io_addr_o,
   output logic             io_wr_o,
   output logic             io_rd_o,
   output logic [7:0]       io_wdata_o,
   input  wire logic [7:0]  io_rdata_i,
   input  wire logic        io_rd_hit_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at time zero
   initial
   begin
      io_addr_o  = 16'h0000;
      io_wr_o    = 1'b0;
      io_rd_o    = 1'b0;
      io_wdata_o = 8'h00;
   end

   // One strobe held over one rising edge; a released bus shows the inverse, not stale data
   task automatic bus_cyc(input logic [15:0] addr, input logic [7:0] data, input logic rd);
      @(negedge clk_i);
      io_addr_o  = addr;
      io_wdata_o = data;
      io_wr_o    = !rd;
      io_rd_o    = rd;
      @(posedge clk_i);
      @(negedge clk_i);
      io_wr_o    = 1'b0;
      io_rd_o    = 1'b0;
      io_addr_o  = ~addr;
      io_wdata_o = ~data;
   endtask : bus_cyc

   // Index write, then data write
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
      bus_cyc(16'h03CE, idx, 1'b0);
      bus_cyc(16'h03CF, data, 1'b0);
   endtask : reg_wr

   // Index write, then data read; the answer is awaited a bounded number of cycles
   task automatic reg_rd(input logic [7:0] idx, output logic [7:0] data, output logic hit);
      hit  = 1'b0;
      data = 8'h00;
      bus_cyc(16'h03CE, idx, 1'b0);
      bus_cyc(16'h03CF, 8'h00, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         if (io_rd_hit_i === 1'b1)
         begin
            hit  = 1'b1;
            data = io_rdata_i;
            break;
         end
         @(negedge clk_i);
      end
   endtask : reg_rd
endmodule : dmbo_host_model

// ==== verification/testbench.sv ====
// Self-checking bench for the display memory bank offset block
`define CHK(nm, exp, got) \
   begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk, rst, io_wr, io_rd, io_rd_hit, lin_mode, pci, dual, m45;
   logic                     sel_o, blk_o, h;
   logic [15:0]              io_addr, fgo, bgo, bmask, lfsr;
   logic [7:0]               io_wdata, io_rdata, fg, bg, fgx, bgx, pmask, o0, o1, md, d;
   logic [3:0]               lin_page, page_o;
   logic [1:0]               map_sel;
   logic [8:0]               pre;
   dmbo_pkg::dmbo_cpu_addr_t cpu_addr;
   dmbo_pkg::dmbo_wr_mode_t  wrm, ew;
   int                       mismatches, n_compared;

   dmbo_host_model i_host (.clk_i(clk), .io_addr_o(io_addr), .io_wr_o(io_wr),
      .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .io_rd_hit_i(io_rd_hit));
   dmbo_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .IO_ADDR_I(io_addr), .IO_WR_I(io_wr),
      .IO_RD_I(io_rd), .IO_WDATA_I(io_wdata), .IO_RDATA_O(io_rdata), .IO_RD_HIT_O(io_rd_hit),
      .CPU_ADDR_I(cpu_addr), .LINEAR_MODE_I(lin_mode), .LINEAR_PAGE_REG_I(lin_page),
      .MEMORY_MAP_SELECT_REG_I(map_sel), .PCI_MODE_I(pci), .DUAL_BE_APERTURE_I(dual),
      .EXT_WR_MODE45_I(m45), .FG_COLOR_I(fg), .BG_COLOR_I(bg), .FOREGROUND_COLOR_EXT_I(fgx),
      .BACKGROUND_COLOR_EXT_I(bgx), .PLANE_WRITE_MASK_I(pmask),
      .PREWRAP_MEMORY_ADDRESS_O(pre), .OFFSET_SELECT_O(sel_o), .OFFSETS_BLOCKED_O(blk_o),
      .LINEAR_PAGE_O(page_o), .WR_MODE_O(wrm), .FG_COLOR_O(fgo), .BG_COLOR_O(bgo),
      .BYTE_WRITE_MASK_O(bmask));

   // Free-running 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict and end of run
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // Next random word; a plain shift register keeps the run repeatable
   function automatic void rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   endfunction : rnd

   // Expected pre-wrap address bits 20..12; the carry out of the sum is lost on purpose
   function automatic logic [8:0] exp_addr();
      logic [7:0] of, f;
      logic [6:0] u;
      logic [1:0] x;
      of   = (pci & dual) ? 8'h00 : ((md[0] & cpu_addr.a[3]) ? o1 : o0);
      x[1] = (map_sel == 2'h1 || md[0]) ? 1'b0 : cpu_addr.a[4];
      x[0] = md[0] ? 1'b0 : cpu_addr.a[3];
      f    = {3'h0, x, cpu_addr.a[2:0]} + of;
      // The linear sum still sees the forced bits 16..15
      u    = lin_mode ? {cpu_addr.la, x, cpu_addr.a[2]} + of[6:0]
                      : {4'h0, x, cpu_addr.a[2]} + of[6:0];
      return md[5] ? {u, cpu_addr.a[1:0]} : {1'b0, f};
   endfunction : exp_addr

   // Expected write path configuration
   function automatic dmbo_pkg::dmbo_wr_mode_t exp_wm();
      dmbo_pkg::dmbo_wr_mode_t w;
      logic                    e, b8;
      e            = md[2] & md[4] & m45;
      b8           = md[1] & !(md[2] & md[4]);
      w.shift      = e ? 3'h4 : (b8 ? 3'h3 : 3'h0);
      w.xfer_bytes = e ? 5'h10 : (b8 ? 5'h08 : 5'h01);
      w.latch8     = md[3];
      w.color_ext  = e;
      w.mask_dbl   = e;
      return w;
   endfunction : exp_wm

   // Expected byte mask: one plane bit per pixel of two bytes when enhanced
   function automatic logic [15:0] exp_mask(input logic e);
      logic [15:0] m;
      for (int j = 0; j < 16; j++)
         m[j] = e ? pmask[j / 2] : ((j < 8) ? pmask[j % 8] : 1'b0);
      return m;
   endfunction : exp_mask

   // Watchdog against a hung sequence
   initial
   begin
      repeat (50000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   // Main sequence
   initial
   begin
      {rst, cpu_addr, lin_mode, lin_page, map_sel, pci, dual, m45} = '1;
      {fg, bg, fgx, bgx, pmask} = '0;
      lfsr = 16'h003A;
      mismatches = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      `CHK("address in reset", 9'h000, pre)
      @(negedge clk);
      rst = 1'b0;
      for (int r = 0; r < 2; r++)
      begin
         // Reset contents, then write and read back each register
         o0 = 8'h0F;
         o1 = 8'h0F;
         md = 8'h0F;
         i_host.reg_rd(8'h09, d, h);
         `CHK("offset zero reset", o0, d)
         i_host.reg_rd(8'h0A, d, h);
         `CHK("offset one reset", o1, d)
         i_host.reg_rd(8'h0B, d, h);
         `CHK("mode reset", md, d)
         for (logic [7:0] i = 8'h09; i < 8'h0C; i++)
         begin
            rnd();
            i_host.reg_wr(i, lfsr[7:0]);
            i_host.reg_rd(i, d, h);
            `CHK("register readback", (i == 8'h0B) ? lfsr[7:0] & 8'h3F : lfsr[7:0], d)
         end
         // Unclaimed index and port are ignored
         i_host.reg_wr(8'h0C, 8'h5A);
         i_host.reg_rd(8'h0C, d, h);
         `CHK("unmapped read hit", 1'b0, h)
         // A stray port must not move the index off the unclaimed 0C
         i_host.bus_cyc(16'h03CD, 8'h0B, 1'b0);
         i_host.bus_cyc(16'h03CF, 8'h00, 1'b1);
         `CHK("index after stray write", 1'b0, io_rd_hit)
         i_host.bus_cyc(16'h03CE, 8'h00, 1'b1);
         `CHK("index port read", 8'h0C, io_rdata)
         i_host.reg_rd(8'h0B, d, h);
         `CHK("mapped read hit", 1'b1, h)
         $display("register test %0d done", r);
         if (r == 0)
         begin
            // Second reset in mid-run
            @(negedge clk);
            rst = 1'b1;
            @(negedge clk);
            `CHK("address in reset", 9'h000, pre)
            rst = 1'b0;
         end
      end
      // Address and write path: corner modes with full offsets first, then random
      for (int n = 0; n < 400; n++)
      begin
         if (n % 16 == 0)
         begin
            rnd();
            // Every other random mode forces pixel enhancement and extended writes on; m45 still gates the enhanced path
            md = 8'((n < 128) ? ((n == 0) ? 8'h00 : 8'h01 << (n / 16 - 1)) | 8'h21 * (n / 64)
                              : (lfsr[7:0] & 8'h3F) | ((n % 32 == 0) ? 8'h14 : 8'h00));
            o0 = (n < 128) ? 8'hFF : lfsr[15:8];
            rnd();
            o1 = (n < 128) ? 8'hFE : lfsr[7:0];
            i_host.reg_wr(8'h09, o0);
            i_host.reg_wr(8'h0A, o1);
            i_host.reg_wr(8'h0B, md);
         end
         rnd();
         {cpu_addr, lin_mode, map_sel} = lfsr;
         rnd();
         {lin_page, pci, dual, m45, fg} = lfsr[14:0];
         rnd();
         {bg, fgx} = lfsr;
         rnd();
         {bgx, pmask} = lfsr;
         @(posedge clk);
         @(negedge clk);
         ew = exp_wm();
         `CHK("prewrap address", exp_addr(), pre)
         `CHK("offset select", md[0] & cpu_addr.a[3], sel_o)
         `CHK("offsets blocked", pci & dual, blk_o)
         `CHK("linear page", md[5] ? {lin_page[3:1], 1'b0} : lin_page, page_o)
         `CHK("write mode", ew, wrm)
         `CHK("fg colour", {ew.color_ext ? fgx : 8'h00, fg}, fgo)
         `CHK("bg colour", {ew.color_ext ? bgx : 8'h00, bg}, bgo)
         `CHK("byte mask", exp_mask(ew.mask_dbl), bmask)
      end
      $display("address path test done");
      end_of_test();
   end
endmodule : testbench
